// file: windowed_watchdog_timer_test.sv
`timescale 1ns/1ps
`include "wwdt_defines.svh"

module windowed_watchdog_timer_test;
    logic                    CLK_SYS_IN;
    logic                    RESET_N_IN;
    logic [`WWDT_ADDR_W-1:0] AVS_ADDRESS_IN;
    logic                    AVS_READ_IN;
    logic                    AVS_WRITE_IN;
    logic [31:0]             AVS_WRITEDATA_IN;
    logic [31:0]             AVS_READDATA_OUT;
    logic                    AVS_WAITREQUEST_OUT;
    logic                    CLK_SWITCH_DONE_IN;
    logic                    FSCM_SWITCH_DONE_IN;
    logic                    WAKE_EVENT_IN;
    logic                    WDT_RESET_OUT;
    logic                    WAKE_OUT;
    logic                    LOW_POWER_RC_OSC_EN_OUT;
    logic [1:0]              PWR_STATE_OUT;
    int                      bad_count;
    int                      cmp_count;
    logic [31:0]             rd;
    logic                    got_rst;
    logic                    got_wk;
    int                      cyc;
    longint                  t0;

    wwdt_top wwdt_top_inst (
        .CLK_SYS_IN          (CLK_SYS_IN),
        .RESET_N_IN          (RESET_N_IN),
        .AVS_ADDRESS_IN      (AVS_ADDRESS_IN),
        .AVS_READ_IN         (AVS_READ_IN),
        .AVS_WRITE_IN        (AVS_WRITE_IN),
        .AVS_WRITEDATA_IN    (AVS_WRITEDATA_IN),
        .AVS_READDATA_OUT    (AVS_READDATA_OUT),
        .AVS_WAITREQUEST_OUT (AVS_WAITREQUEST_OUT),
        .CLK_SWITCH_DONE_IN  (CLK_SWITCH_DONE_IN),
        .FSCM_SWITCH_DONE_IN (FSCM_SWITCH_DONE_IN),
        .WAKE_EVENT_IN       (WAKE_EVENT_IN),
        .WDT_RESET_OUT       (WDT_RESET_OUT),
        .WAKE_OUT            (WAKE_OUT),
        .LOW_POWER_RC_OSC_EN_OUT         (LOW_POWER_RC_OSC_EN_OUT),
        .PWR_STATE_OUT       (PWR_STATE_OUT)
    );

    initial begin
        CLK_SYS_IN = 1'b0;
        forever #12.5 CLK_SYS_IN = ~CLK_SYS_IN;
    end

    task automatic finish_test();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
            bad_count++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS_IN);
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        got_rst = 1'b0;
        got_wk  = 1'b0;
        AVS_ADDRESS_IN   <= a;
        AVS_WRITEDATA_IN <= d;
        AVS_WRITE_IN     <= wr;
        AVS_READ_IN      <= ~wr;
        do begin
            @(posedge CLK_SYS_IN);
            n++;
        end while (AVS_WAITREQUEST_OUT !== 1'b0 && n < 50);
        rd = AVS_READDATA_OUT;
        if (n >= 50) begin
            $display("Error at %0t: bus answer missing", $time);
            bad_count++;
        end
        AVS_WRITE_IN <= 1'b0;
        AVS_READ_IN  <= 1'b0;
        @(posedge CLK_SYS_IN);
    endtask

    task automatic pulse(input int which);
        CLK_SWITCH_DONE_IN  <= (which == 0);
        FSCM_SWITCH_DONE_IN <= (which == 1);
        WAKE_EVENT_IN       <= (which == 2);
        @(posedge CLK_SYS_IN);
        CLK_SWITCH_DONE_IN  <= 1'b0;
        FSCM_SWITCH_DONE_IN <= 1'b0;
        WAKE_EVENT_IN       <= 1'b0;
    endtask

    // Pulses stand one cycle and may end inside a bus call, so latch them
    always @(posedge CLK_SYS_IN) begin
        if (WDT_RESET_OUT === 1'b1) begin
            got_rst = 1'b1;
        end
        if (WAKE_OUT === 1'b1) begin
            got_wk = 1'b1;
        end
    end

    // Bounded wait for either reset or wake pulse, armed by the last bus call
    task automatic wait_evt(input int lim);
        for (cyc = 0; cyc < lim && !(got_rst || got_wk); cyc++) begin
            @(negedge CLK_SYS_IN);
        end
        cyc = int'(($time - t0) / `WWDT_CLK_PERIOD_NS);
    endtask

    initial begin
        #3000000;
        $display("Error at %0t: watchdog limit reached", $time);
        bad_count++;
        finish_test();
    end

    initial begin
        bad_count = 0;
        cmp_count = 0;
        RESET_N_IN = 1'b0;
        AVS_ADDRESS_IN = 4'h0;
        AVS_READ_IN = 1'b0;
        AVS_WRITE_IN = 1'b0;
        AVS_WRITEDATA_IN = 32'h0000_0000;
        CLK_SWITCH_DONE_IN = 1'b0;
        FSCM_SWITCH_DONE_IN = 1'b0;
        WAKE_EVENT_IN = 1'b0;
        t0 = 0;
        tick(20);
        RESET_N_IN <= 1'b1;
        tick(1);
        bus(1'b0, `WWDT_ADDR_CFG, 32'h0);  chk(rd, 32'h0000_8380, "cfg reset");
        bus(1'b0, `WWDT_ADDR_RCTL, 32'h0); chk(rd, 32'h0000_0000, "rctl reset");
        bus(1'b1, 4'h1, 32'hFFFF_FFFF);
        bus(1'b0, 4'h1, 32'h0);            chk(rd, 32'h0000_0000, "unmapped read");
        bus(1'b0, `WWDT_ADDR_CMD, 32'h0);  chk(rd, 32'h0000_0000, "cmd read");
        bus(1'b0, `WWDT_ADDR_CFG, 32'h0);  chk(rd, 32'h0000_8380, "cfg after stray");
        chk({31'h0, LOW_POWER_RC_OSC_EN_OUT}, 32'h0000_0000, "osc off by default");
        bus(1'b1, `WWDT_ADDR_RCTL, 32'h0000_0020);
        tick(2);
        chk({31'h0, LOW_POWER_RC_OSC_EN_OUT}, 32'h0000_0001, "soft enable");
        tick(3000);
        bus(1'b0, `WWDT_ADDR_STAT, 32'h0);
        chk({31'h0, (rd[21:0] != 22'h0)}, 32'h0000_0001, "counting");
        bus(1'b1, `WWDT_ADDR_CMD, 32'h0000_0001);
        bus(1'b0, `WWDT_ADDR_STAT, 32'h0); chk({11'h0, rd[21:1]}, 32'h0, "clr");
        for (int k = 0; k < 2; k++) begin
            tick(3000);
            pulse(k);
            tick(1);
            bus(1'b0, `WWDT_ADDR_STAT, 32'h0);
            chk({11'h0, rd[21:1]}, 32'h0, "switch clears count");
        end
        // Early clear inside window mode
        bus(1'b1, `WWDT_ADDR_CFG, 32'h0000_8300);
        t0 = $time;
        bus(1'b1, `WWDT_ADDR_CMD, 32'h0000_0001);
        wait_evt(10);
        chk({30'h0, got_rst, got_wk}, 32'h0000_0002, "early clear reset");
        tick(2);
        chk({31'h0, LOW_POWER_RC_OSC_EN_OUT}, 32'h0000_0000, "soft enable dropped");
        tick(100);
        bus(1'b0, `WWDT_ADDR_RCTL, 32'h0); chk(rd, 32'h0000_0010, "sticky flag");
        bus(1'b1, `WWDT_ADDR_RCTL, 32'h0000_0000);
        bus(1'b0, `WWDT_ADDR_RCTL, 32'h0); chk(rd, 32'h0000_0000, "flag cleared");
        // Forced enable, then time-out in sleep
        bus(1'b1, `WWDT_ADDR_CFG, 32'h0000_C380);
        tick(2);
        chk({31'h0, LOW_POWER_RC_OSC_EN_OUT}, 32'h0000_0001, "forced on");
        tick(2000);
        bus(1'b1, `WWDT_ADDR_CMD, 32'h0000_0002);
        t0 = $time;
        chk({30'h0, PWR_STATE_OUT}, 32'h0000_0001, "asleep");
        bus(1'b0, `WWDT_ADDR_RCTL, 32'h0); chk(rd, 32'h0000_0008, "sleep flag");
        bus(1'b0, `WWDT_ADDR_STAT, 32'h0); chk({11'h0, rd[21:1]}, 32'h0, "entry");
        wait_evt(41000);
        chk({30'h0, got_rst, got_wk}, 32'h0000_0001, "wake not reset");
        chk({31'h0, (cyc >= 38700 && cyc <= 40010)}, 32'h1, "sleep period");
        tick(1);
        chk({30'h0, PWR_STATE_OUT}, 32'h0000_0000, "running again");
        bus(1'b0, `WWDT_ADDR_STAT, 32'h0); chk({11'h0, rd[21:1]}, 32'h0, "exit");
        bus(1'b0, `WWDT_ADDR_RCTL, 32'h0); chk(rd, 32'h0000_0018, "wake flags");
        bus(1'b1, `WWDT_ADDR_RCTL, 32'h0000_0000);
        // Idle left by another wake source
        bus(1'b1, `WWDT_ADDR_CMD, 32'h0000_0004);
        bus(1'b0, `WWDT_ADDR_RCTL, 32'h0); chk(rd, 32'h0000_0004, "idle flag");
        chk({30'h0, PWR_STATE_OUT}, 32'h0000_0002, "idle state");
        tick(2000);
        bus(1'b0, `WWDT_ADDR_STAT, 32'h0);
        chk({31'h0, (rd[21:0] != 22'h0)}, 32'h1, "counts in idle");
        pulse(2);
        t0 = $time;
        wait_evt(5);
        chk({30'h0, got_rst, got_wk}, 32'h0000_0001, "idle wake");
        tick(1);
        bus(1'b0, `WWDT_ADDR_STAT, 32'h0); chk({11'h0, rd[21:1]}, 32'h0, "exit");
        // Clear inside the open window is accepted
        bus(1'b1, `WWDT_ADDR_CFG, 32'h0000_C300);
        tick(11000);
        bus(1'b1, `WWDT_ADDR_CMD, 32'h0000_0001);
        tick(3);
        chk({31'h0, got_rst}, 32'h0000_0000, "window clear no reset");
        bus(1'b0, `WWDT_ADDR_STAT, 32'h0); chk({11'h0, rd[21:1]}, 32'h0, "win clr");
        bus(1'b1, `WWDT_ADDR_CFG, 32'h0000_C380);
        // Time-out while running, shortest period
        bus(1'b1, `WWDT_ADDR_RCTL, 32'h0000_0000);
        bus(1'b1, `WWDT_ADDR_CMD, 32'h0000_0001);
        t0 = $time;
        wait_evt(41000);
        chk({30'h0, got_rst, got_wk}, 32'h0000_0002, "run time-out");
        chk({31'h0, (cyc >= 38700 && cyc <= 40010)}, 32'h1, "run period");
        tick(1);
        bus(1'b0, `WWDT_ADDR_RCTL, 32'h0); chk(rd, 32'h0000_0010, "run flag");
        // Second reset in mid-run
        RESET_N_IN <= 1'b0;
        tick(3);
        RESET_N_IN <= 1'b1;
        tick(3);
        chk({31'h0, LOW_POWER_RC_OSC_EN_OUT}, 32'h0000_0000, "osc off after reset");
        bus(1'b0, `WWDT_ADDR_CFG, 32'h0);  chk(rd, 32'h0000_8380, "cfg again");
        bus(1'b0, `WWDT_ADDR_STAT, 32'h0); chk(rd, 32'h0000_0000, "status");
        finish_test();
    end
endmodule

// file: wwdt_defines.svh
`ifndef WWDT_DEFINES_SVH
`define WWDT_DEFINES_SVH

// System clock
`define WWDT_CLK_PERIOD_NS  25
`define WWDT_CLK_HZ         40000000

// Low-power RC oscillator, modelled as a tick of the system clock
`define WWDT_LOW_POWER_RC_OSC_HZ        32000
`define WWDT_LOW_POWER_RC_OSC_DIV       (`WWDT_CLK_HZ / `WWDT_LOW_POWER_RC_OSC_HZ)
`define WWDT_LOW_POWER_RC_OSC_CNT_W     11

// Shortest time-out window, divide-by-32 and postscale 1:1
`define WWDT_TMO_MIN_NS     810000
`define WWDT_TMO_MAX_NS     1220000
`define WWDT_TMO_MIN_CYC    ((`WWDT_TMO_MIN_NS + `WWDT_CLK_PERIOD_NS - 1) / `WWDT_CLK_PERIOD_NS)
`define WWDT_TMO_MAX_CYC    (`WWDT_TMO_MAX_NS / `WWDT_CLK_PERIOD_NS)

// Prescaler stages, as powers of two
`define WWDT_PRE_SHORT_LOG2 5
`define WWDT_PRE_LONG_LOG2  7
`define WWDT_CNT_W          22

// Register byte addresses
`define WWDT_ADDR_W         4
`define WWDT_ADDR_RCTL      4'h0
`define WWDT_ADDR_CFG       4'h4
`define WWDT_ADDR_CMD       4'h8
`define WWDT_ADDR_STAT      4'hC

// Reset control register fields
`define WWDT_RC_SWEN        5
`define WWDT_RC_TMO         4
`define WWDT_RC_SLEEP       3
`define WWDT_RC_IDLE        2

// Configuration word fields
`define WWDT_CF_POST_HI     3
`define WWDT_CF_POST_LO     0
`define WWDT_CF_PRE         4
`define WWDT_CF_WINDOW_DISABLE      7
`define WWDT_CF_WIN_HI      9
`define WWDT_CF_WIN_LO      8
`define WWDT_CF_EN_HI       15
`define WWDT_CF_EN_LO       14
`define WWDT_CF_RESET       16'h8380
`define WWDT_EN_ALWAYS      2'h3
`define WWDT_EN_SOFT        2'h2

// Command register bits
`define WWDT_CMD_CLR        0
`define WWDT_CMD_SLEEP      1
`define WWDT_CMD_IDLE       2

`endif

// file: wwdt_low_power_rc_osc_osc.sv
`timescale 1ns/1ps
`include "wwdt_defines.svh"

module wwdt_low_power_rc_osc_osc (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Control
    input  wire logic enable_in,
    // Oscillator edge, one cycle
    output logic      tick_out
);

    logic [`WWDT_LOW_POWER_RC_OSC_CNT_W-1:0] div_reg;

    // [R1] Oscillator follows enable
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_reg  <= '0;
            tick_out <= 1'b0;
        end else if (!enable_in) begin
            div_reg  <= '0;
            tick_out <= 1'b0;
        end else if (div_reg == `WWDT_LOW_POWER_RC_OSC_CNT_W'(`WWDT_LOW_POWER_RC_OSC_DIV - 1)) begin
            div_reg  <= '0;
            tick_out <= 1'b1;
        end else begin
            div_reg  <= div_reg + 1'b1;
            tick_out <= 1'b0;
        end
    end

    AST_LOW_POWER_RC_OSC_GATED: assert property ( // [R1]
        @(posedge clk_in) disable iff (!rst_n_in)
        tick_out |-> ($past(enable_in) && !$past(tick_out)))
        else $error("Oscillator ticked while disabled");

endmodule

// file: wwdt_pkg.sv
`include "wwdt_defines.svh"

package wwdt_pkg;

    typedef enum logic [1:0] {
        WWDT_RUN,
        WWDT_SLEEP,
        WWDT_IDLE
    } wwdt_pwr_t;

    typedef logic [`WWDT_CNT_W:0] wwdt_period_t;

    // Oscillator ticks in one time-out period
    function automatic wwdt_period_t wwdt_period(input logic pre_long,
                                                 input logic [3:0] post);
        logic [4:0] sh;
        sh = (pre_long ? 5'(`WWDT_PRE_LONG_LOG2) : 5'(`WWDT_PRE_SHORT_LOG2)) + {1'b0, post};
        return wwdt_period_t'(1) << sh;
    endfunction

    // Tick count at which the clearing window opens
    function automatic wwdt_period_t wwdt_win_open(input wwdt_period_t p,
                                                   input logic [1:0] win);
        wwdt_period_t thr;
        thr = p >> 2;
        case (win)
            2'h0: thr = p - (p >> 2);
            2'h1: thr = p - (p >> 2) - (p >> 3);
            2'h2: thr = p >> 1;
            2'h3: thr = p >> 2;
        endcase
        return thr;
    endfunction

endpackage

// file: wwdt_scaler.sv
`timescale 1ns/1ps
`include "wwdt_defines.svh"

module wwdt_scaler (
    // Clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    // Control
    input  wire logic                   tick_in,
    input  wire logic                   run_in,
    input  wire logic                   clear_in,
    input  wire logic                   pre_long_in,
    input  wire logic [3:0]             post_in,
    input  wire logic [1:0]             win_sel_in,
    // Status
    output logic [`WWDT_CNT_W-1:0]      count_out,
    output logic                        expire_out,
    output logic                        win_open_out
);

    wwdt_pkg::wwdt_period_t period;

    // [R2] Prescale and postscale
    assign period       = wwdt_pkg::wwdt_period(pre_long_in, post_in);
    assign expire_out   = tick_in && run_in && ({1'b0, count_out} == period - 1'b1);
    assign win_open_out = {1'b0, count_out} >= wwdt_pkg::wwdt_win_open(period, win_sel_in);

    // One counter spans prescaler and postscaler, so one clear restarts both
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_out <= '0;
        end else if (clear_in || expire_out) begin
            count_out <= '0;
        end else if (tick_in && run_in) begin
            count_out <= count_out + 1'b1;
        end
    end

endmodule

// file: wwdt_top.sv
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "wwdt_defines.svh"

// Notes on behaviour
// [R1] Counter runs from enabled low-power oscillator
// [R2] Prescaler divides by 32 or 128
// [R3] Sixteen postscale ratios, 1:1 to 1:32768
// [R4] Shortest time-out about one millisecond
// [R5] Any device reset clears the counter
// [R6] Completed clock switch clears the counter
// [R7] Entering sleep or idle clears counter
// [R8] Leaving sleep or idle clears counter
// [R9] Clear instruction restarts all counts
// [R10] Counting continues in sleep and idle
// [R11] Time-out in power save wakes device
// [R12] Software clears sleep or idle flag
// [R13] Enable field 11 forces watchdog on
// [R14] Enable field 10 obeys software enable
// [R15] Device reset clears software enable
// [R16] Sticky time-out flag, software clears
// [R17] Window mode active when bit 7 clear
// [R18] Software clears only inside window
// [R19] Running time-out resets and flags
// [R20] Early clear in window mode resets
module wwdt_top (
    // Clock and reset
    input  wire logic                    CLK_SYS_IN,
    input  wire logic                    RESET_N_IN,
    // Avalon-MM slave
    input  wire logic [`WWDT_ADDR_W-1:0] AVS_ADDRESS_IN,
    input  wire logic                    AVS_READ_IN,
    input  wire logic                    AVS_WRITE_IN,
    input  wire logic [31:0]             AVS_WRITEDATA_IN,
    output logic      [31:0]             AVS_READDATA_OUT,
    output logic                         AVS_WAITREQUEST_OUT,
    // Device events
    input  wire logic                    CLK_SWITCH_DONE_IN,
    input  wire logic                    FSCM_SWITCH_DONE_IN,
    input  wire logic                    WAKE_EVENT_IN,
    // Device controls
    output logic                         WDT_RESET_OUT,
    output logic                         WAKE_OUT,
    output logic                         LOW_POWER_RC_OSC_EN_OUT,
    output logic      [1:0]              PWR_STATE_OUT
);

    logic                    ack_reg;
    logic [15:0]             cfg_reg;
    logic                    soft_en_reg;
    logic                    tmo_flag_reg;
    logic                    sleep_flag_reg;
    logic                    idle_flag_reg;
    wwdt_pkg::wwdt_pwr_t     state_reg;
    logic                    bus_wr;
    logic                    wr_rctl;
    logic                    wr_cfg;
    logic                    cmd_clr;
    logic                    cmd_sleep;
    logic                    cmd_idle;
    logic                    wd_on;
    logic                    in_run;
    logic                    low_power_rc_osc_tick;
    logic                    expire;
    logic                    win_open;
    logic                    early_clr;
    logic                    good_clr;
    logic                    wd_reset;
    logic                    wake_tmo;
    logic                    enter_ps;
    logic                    exit_ps;
    logic                    scaler_clr;
    logic [`WWDT_CNT_W-1:0]  count;
    logic [1:0]              en_cfg;

    // Bus slave: one wait cycle, write lands when waitrequest is low
    assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack_reg;
    assign bus_wr    = AVS_WRITE_IN && ack_reg;
    assign wr_rctl   = bus_wr && (AVS_ADDRESS_IN == `WWDT_ADDR_RCTL);
    assign wr_cfg    = bus_wr && (AVS_ADDRESS_IN == `WWDT_ADDR_CFG);
    assign cmd_clr   = bus_wr && (AVS_ADDRESS_IN == `WWDT_ADDR_CMD)
                       && AVS_WRITEDATA_IN[`WWDT_CMD_CLR];
    assign cmd_sleep = bus_wr && (AVS_ADDRESS_IN == `WWDT_ADDR_CMD)
                       && AVS_WRITEDATA_IN[`WWDT_CMD_SLEEP];
    assign cmd_idle  = bus_wr && (AVS_ADDRESS_IN == `WWDT_ADDR_CMD)
                       && AVS_WRITEDATA_IN[`WWDT_CMD_IDLE];

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_reg;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            AVS_READDATA_OUT <= 32'h0000_0000;
        end else if (AVS_READ_IN && !ack_reg) begin
            unique case (AVS_ADDRESS_IN)
                `WWDT_ADDR_RCTL: AVS_READDATA_OUT <= {26'h000_0000, soft_en_reg, tmo_flag_reg,
                                                      sleep_flag_reg, idle_flag_reg, 2'h0};
                `WWDT_ADDR_CFG:  AVS_READDATA_OUT <= {16'h0000, cfg_reg};
                `WWDT_ADDR_STAT: AVS_READDATA_OUT <= {3'h0, win_open, 2'h0, state_reg,
                                                      2'h0, count};
                default:         AVS_READDATA_OUT <= 32'h0000_0000;
            endcase
        end
    end

    // Enable decode
    assign en_cfg = cfg_reg[`WWDT_CF_EN_HI:`WWDT_CF_EN_LO];
    // [R13] Forced enable
    // [R14] Software enable
    assign wd_on  = (en_cfg == `WWDT_EN_ALWAYS) || ((en_cfg == `WWDT_EN_SOFT) && soft_en_reg);
    assign in_run = (state_reg == wwdt_pkg::WWDT_RUN);

    // [R18] Window violation check
    // [R20] Early clear resets
    assign early_clr = cmd_clr && in_run && wd_on && !cfg_reg[`WWDT_CF_WINDOW_DISABLE] && !win_open;
    // [R9] Clear instruction restart
    assign good_clr  = cmd_clr && in_run && !early_clr;
    // [R19] Run time-out reset
    assign wd_reset  = in_run && (expire || early_clr);
    // [R11] Wake on time-out
    assign wake_tmo  = !in_run && expire;
    assign enter_ps  = in_run && (cmd_sleep || cmd_idle) && !wd_reset;
    assign exit_ps   = !in_run && (expire || WAKE_EVENT_IN);
    // [R5] Clear on watchdog reset
    // [R6] Clear on clock switch
    // [R7] Clear on power save
    // [R8] Clear on wake
    assign scaler_clr = wd_reset || CLK_SWITCH_DONE_IN || FSCM_SWITCH_DONE_IN
                        || enter_ps || exit_ps || good_clr || !wd_on;

    wwdt_low_power_rc_osc_osc u_osc (
        .clk_in    (CLK_SYS_IN),
        .rst_n_in  (RESET_N_IN),
        .enable_in (wd_on),
        .tick_out  (low_power_rc_osc_tick)
    );

    // [R10] Counts in every mode
    wwdt_scaler u_scaler (
        .clk_in       (CLK_SYS_IN),
        .rst_n_in     (RESET_N_IN),
        .tick_in      (low_power_rc_osc_tick),
        .run_in       (wd_on),
        .clear_in     (scaler_clr),
        .pre_long_in  (cfg_reg[`WWDT_CF_PRE]),
        .post_in      (cfg_reg[`WWDT_CF_POST_HI:`WWDT_CF_POST_LO]),
        .win_sel_in   (cfg_reg[`WWDT_CF_WIN_HI:`WWDT_CF_WIN_LO]),
        .count_out    (count),
        .expire_out   (expire),
        .win_open_out (win_open)
    );

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            cfg_reg <= `WWDT_CF_RESET;
        end else if (wr_cfg) begin
            cfg_reg <= AVS_WRITEDATA_IN[15:0];
        end
    end

    // [R15] Reset drops software enable
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            soft_en_reg <= 1'b0;
        end else if (wd_reset) begin
            soft_en_reg <= 1'b0;
        end else if (wr_rctl) begin
            soft_en_reg <= AVS_WRITEDATA_IN[`WWDT_RC_SWEN];
        end
    end

    // [R16] Sticky flag, set wins
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            tmo_flag_reg <= 1'b0;
        end else if (wd_reset || wake_tmo) begin
            tmo_flag_reg <= 1'b1;
        end else if (wr_rctl && !AVS_WRITEDATA_IN[`WWDT_RC_TMO]) begin
            tmo_flag_reg <= 1'b0;
        end
    end

    // [R12] Mode flags cleared by software
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            sleep_flag_reg <= 1'b0;
            idle_flag_reg  <= 1'b0;
        end else begin
            if (enter_ps && cmd_sleep) begin
                sleep_flag_reg <= 1'b1;
            end else if (wr_rctl && !AVS_WRITEDATA_IN[`WWDT_RC_SLEEP]) begin
                sleep_flag_reg <= 1'b0;
            end
            if (enter_ps && !cmd_sleep) begin
                idle_flag_reg <= 1'b1;
            end else if (wr_rctl && !AVS_WRITEDATA_IN[`WWDT_RC_IDLE]) begin
                idle_flag_reg <= 1'b0;
            end
        end
    end

    // Sleep wins when both power-save bits are written together
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_reg <= wwdt_pkg::WWDT_RUN;
        end else if (wd_reset || exit_ps) begin
            state_reg <= wwdt_pkg::WWDT_RUN;
        end else if (enter_ps) begin
            state_reg <= cmd_sleep ? wwdt_pkg::WWDT_SLEEP : wwdt_pkg::WWDT_IDLE;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            WDT_RESET_OUT <= 1'b0;
            WAKE_OUT      <= 1'b0;
            LOW_POWER_RC_OSC_EN_OUT   <= 1'b0;
        end else begin
            WDT_RESET_OUT <= wd_reset;
            WAKE_OUT      <= exit_ps;
            LOW_POWER_RC_OSC_EN_OUT   <= wd_on;
        end
    end

    assign PWR_STATE_OUT = state_reg;

    // Checking helpers: ticks and cycles since the last restart
    logic [`WWDT_CNT_W:0] ticks_reg;
    logic [31:0]          cyc_reg;

    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ticks_reg <= '0;
            cyc_reg   <= 32'h0000_0000;
        end else if (scaler_clr || expire) begin
            ticks_reg <= '0;
            cyc_reg   <= 32'h0000_0000;
        end else begin
            ticks_reg <= ticks_reg + (low_power_rc_osc_tick ? 1'b1 : 1'b0);
            cyc_reg   <= cyc_reg + 1'b1;
        end
    end

    AST_PERIOD_TICKS: assert property ( // [R3]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        expire |-> (ticks_reg + 1'b1 == wwdt_pkg::wwdt_period(cfg_reg[`WWDT_CF_PRE],
                                        cfg_reg[`WWDT_CF_POST_HI:`WWDT_CF_POST_LO])))
        else $error("Time-out after wrong tick count");

    AST_SHORT_TIMEOUT: assert property ( // [R4]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        (expire && !cfg_reg[`WWDT_CF_PRE] && (cfg_reg[`WWDT_CF_POST_HI:`WWDT_CF_POST_LO] == 4'h0))
        |-> (cyc_reg >= `WWDT_TMO_MIN_CYC && cyc_reg <= `WWDT_TMO_MAX_CYC))
        else $error("Shortest time-out out of range");

    AST_RESET_CLEARS: assert property ( // [R5]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        WDT_RESET_OUT |-> (count == '0 && !soft_en_reg && in_run))
        else $error("Watchdog reset left state behind");

    AST_SWITCH_CLEARS: assert property ( // [R6]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        (CLK_SWITCH_DONE_IN || FSCM_SWITCH_DONE_IN) |=> (count == '0))
        else $error("Clock switch did not clear counter");

    AST_ENTER_PS: assert property ( // [R7]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        enter_ps |=> (!in_run && count == '0 && (sleep_flag_reg || idle_flag_reg)))
        else $error("Power-save entry mishandled");

    AST_WAKE_CLEARS: assert property ( // [R8]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        exit_ps |=> (in_run && WAKE_OUT && count == '0))
        else $error("Wake did not restart counter");

    AST_CLEAR_INSTR: assert property ( // [R9]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        good_clr |=> (count == '0 && !WDT_RESET_OUT))
        else $error("Clear instruction not honoured");

    AST_SLEEP_COUNTS: assert property ( // [R10]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        (!in_run && low_power_rc_osc_tick && !scaler_clr) |=> (count == $past(count) + 1'b1))
        else $error("Counter stalled in power save");

    AST_WAKE_NO_RESET: assert property ( // [R11]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        wake_tmo |=> (WAKE_OUT && !WDT_RESET_OUT && tmo_flag_reg))
        else $error("Power-save time-out caused reset");

    AST_FORCED_ON: assert property ( // [R13]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        (en_cfg == `WWDT_EN_ALWAYS) [*2] |-> LOW_POWER_RC_OSC_EN_OUT)
        else $error("Forced enable not running");

    AST_SOFT_OFF: assert property ( // [R14]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        ((en_cfg == `WWDT_EN_SOFT) && !soft_en_reg) [*2] |-> (!LOW_POWER_RC_OSC_EN_OUT && count == '0))
        else $error("Watchdog ran without software enable");

    AST_FLAG_STICKY: assert property ( // [R16]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        (tmo_flag_reg && !(wr_rctl && !AVS_WRITEDATA_IN[`WWDT_RC_TMO])) |=> tmo_flag_reg)
        else $error("Time-out flag cleared by hardware");

    AST_WINDOW_EARLY: assert property ( // [R17]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        (cmd_clr && in_run && wd_on && !cfg_reg[`WWDT_CF_WINDOW_DISABLE] && !win_open)
        |=> (WDT_RESET_OUT && tmo_flag_reg))
        else $error("Early clear in window mode not punished");

    AST_RUN_TIMEOUT: assert property ( // [R19]
        @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
        (in_run && expire) |=> (WDT_RESET_OUT && tmo_flag_reg && !WAKE_OUT))
        else $error("Run time-out did not reset");

endmodule
